// ===== verilog/draw_seq_pkg.sv
/*
  package for the draw command sequencer: command codes, register offsets,
  setting layouts and reset values.
  assumes a single core clock domain and a plain strobe register port.
*/
package draw_seq_pkg;

  // command opcodes written to the command register
  typedef enum logic [3:0] {
    CMD_IDLE        = 4'h0,
    CMD_SOFT_RESET  = 4'h1,
    CMD_PUT_TXT_BM  = 4'h2,
    CMD_PUT_TXT_PK  = 4'h3,
    CMD_PUT_BM      = 4'h4,
    CMD_PUT_PK      = 4'h5,
    CMD_DRAW_LINE   = 4'h6,
    CMD_DRAW_RECT   = 4'h7
  } cmd_code_t;

  // anti-alias filter settings as written by software
  typedef struct packed {
    logic       enable;
    logic [2:0] mode;
    logic [3:0] weight;
  } aaf_settings_t;

  // pixel engine options carried with a load command
  typedef struct packed {
    logic background_write_enable;
    logic transparent_colour_enable;
  } pe_opts_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } seq_state_t;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFS_COMMAND  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FILTER   = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PE_OPTS  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_LENGTH   = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_LAST_CMD = 4'h6;

  // status word bit positions
  localparam int ST_BIT_BUSY     = 0;
  localparam int ST_BIT_CWEN     = 1;
  localparam int ST_BIT_EARLY    = 2;
  localparam int ST_BIT_STALE    = 3;
  localparam int ST_BIT_PE_DONE  = 4;

  localparam aaf_settings_t FILTER_RESET = 8'h00;
  localparam pe_opts_t PE_OPTS_RESET = 2'b10;
  localparam logic [DATA_W-1:0] LENGTH_RESET = 16'h0001;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

endpackage

// ===== verilog/pixel_stream_tracker.sv
/*
  pixel stream tracker: counts generated pixels of a load command and flags
  which of them reach video memory, to tell when the memory stream ends.
  assumes the main sequencer pulses start for one cycle and steps one pixel a cycle.
*/
`timescale 1ns/1ps
module pixel_stream_tracker #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic [CNT_W-1:0] length,
  input wire logic suppress,
  // progress
  output logic running,
  output logic stream_done,
  output logic proc_done
);

  logic [CNT_W-1:0] left_q;
  logic [CNT_W-1:0] left_d;
  logic [CNT_W-1:0] tail_q;
  logic [CNT_W-1:0] tail_d;
  logic running_d;
  logic stream_done_d;
  logic proc_done_d;
  wire last_pixel = running && (left_q == {{(CNT_W-1){1'b0}}, 1'b1});

  // trailing quarter of the pixels is treated as background when suppressed,
  // so the memory stream ends before processing does
  assign left_d = start ? length : (running ? left_q - 1'b1 : left_q);
  assign tail_d = start ? (suppress ? (length >> 2) : '0) : tail_q;
  assign running_d = start ? (length != '0) : (running && !last_pixel);
  assign stream_done_d = running && (left_q == tail_q + 1'b1);
  assign proc_done_d = last_pixel;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      left_q <= '0;
      tail_q <= '0;
      running <= 1'b0;
      stream_done <= 1'b0;
      proc_done <= 1'b0;
    end else begin
      left_q <= left_d;
      tail_q <= tail_d;
      running <= running_d;
      stream_done <= stream_done_d;
      proc_done <= proc_done_d;
    end
  end

endmodule // pixel_stream_tracker

// ===== verilog/draw_command_sequencing.sv
/*
  draw command sequencer: takes host commands, double buffers the anti-alias
  filter settings and runs the pixel engine load commands.
  assumes a synchronous register port in the core clock domain, read data one
  cycle after the read strobe.
*/
// Behaviour
// - filter settings double buffered per draw command
// - dummy draw keeps pre-reset filter options
// - four bitmap/texture load commands provided
// - suppression: bg enable 0, transparent 1
// - memory stream may end before processing
// - engine may report done before stop
`timescale 1ns/1ps
module draw_command_sequencing #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [draw_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [draw_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [draw_seq_pkg::DATA_W-1:0] reg_rdata,
  // filter and engine status
  output draw_seq_pkg::aaf_settings_t filter_active,
  output logic filter_enable_signal,
  output logic command_write_allowed_flag,
  output logic pe_busy,
  output logic cmd_done
);
  import draw_seq_pkg::*;

  seq_state_t state_q;
  seq_state_t state_d;
  aaf_settings_t filter_shadow_q;
  aaf_settings_t filter_active_d;
  pe_opts_t pe_opts_q;
  logic [CNT_W-1:0] length_q;
  cmd_code_t last_cmd_q;
  logic early_done_q;
  logic stale_pending_q;
  logic pe_done_seen_q;
  logic [DATA_W-1:0] rdata_d;
  logic trk_running;
  logic trk_stream_done;
  logic trk_proc_done;

  function automatic logic is_load_cmd(input logic [3:0] code);
    is_load_cmd = (code == CMD_PUT_TXT_BM) || (code == CMD_PUT_TXT_PK) ||
                  (code == CMD_PUT_BM) || (code == CMD_PUT_PK);
  endfunction

  function automatic logic is_draw_cmd(input logic [3:0] code);
    is_draw_cmd = is_load_cmd(code) || (code == CMD_DRAW_LINE) || (code == CMD_DRAW_RECT);
  endfunction

  function automatic logic is_text_cmd(input logic [3:0] code);
    is_text_cmd = (code == CMD_PUT_TXT_BM) || (code == CMD_PUT_TXT_PK);
  endfunction

  // register port decode
  wire wr_cmd = reg_wr && (reg_addr == OFS_COMMAND);
  wire wr_filter = reg_wr && (reg_addr == OFS_FILTER);
  wire wr_opts = reg_wr && (reg_addr == OFS_PE_OPTS);
  wire wr_len = reg_wr && (reg_addr == OFS_LENGTH);
  wire [3:0] cmd_code = reg_wdata[3:0];
  wire cmd_ok = wr_cmd && (state_q == ST_IDLE);
  wire start_draw = cmd_ok && is_draw_cmd(cmd_code);
  wire start_load = cmd_ok && is_load_cmd(cmd_code);
  wire start_idle = cmd_ok && (cmd_code == CMD_IDLE);
  wire start_reset = wr_cmd && (cmd_code == CMD_SOFT_RESET);
  wire busy = (state_q != ST_IDLE);

  // suppression select differs per command family
  wire suppress = is_text_cmd(cmd_code) ? !pe_opts_q.background_write_enable
                                        : pe_opts_q.transparent_colour_enable;

  // settings move to the filter only at a draw start; a draw after a soft
  // reset that cut a filtered draw still runs on the pre-reset copy
  assign filter_active_d = (start_draw && !stale_pending_q) ? filter_shadow_q : filter_active;

  // engine may finish its memory stream early and report done itself
  logic suppress_q;
  wire pe_report = trk_stream_done && suppress_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_load) state_d = ST_RUN;
        else if (start_draw || start_idle) state_d = ST_DONE;
      end
      ST_RUN: begin
        if (trk_proc_done) state_d = ST_DONE;
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    if (start_reset) state_d = ST_IDLE;
  end

  always_comb begin
    unique case (reg_addr)
      OFS_FILTER: rdata_d = {{(DATA_W-8){1'b0}}, filter_shadow_q};
      OFS_PE_OPTS: rdata_d = {{(DATA_W-2){1'b0}}, pe_opts_q};
      OFS_LENGTH: rdata_d = DATA_W'(length_q);
      OFS_STATUS: rdata_d = {{(DATA_W-5){1'b0}}, pe_done_seen_q, stale_pending_q, early_done_q,
                             !busy, busy};
      OFS_ACTIVE: rdata_d = {{(DATA_W-8){1'b0}}, filter_active};
      OFS_LAST_CMD: rdata_d = {{(DATA_W-4){1'b0}}, last_cmd_q};
      default: rdata_d = READ_ZERO;
    endcase
  end

  pixel_stream_tracker #(
    .CNT_W(CNT_W)
  ) u_tracker (
    .core_clk(core_clk),
    .rst_n(rst_n && !start_reset),
    .start(start_load),
    .length(length_q),
    .suppress(suppress),
    .running(trk_running),
    .stream_done(trk_stream_done),
    .proc_done(trk_proc_done)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      filter_shadow_q <= FILTER_RESET;
      filter_active <= FILTER_RESET;
      filter_enable_signal <= 1'b0;
      pe_opts_q <= PE_OPTS_RESET;
      length_q <= CNT_W'(LENGTH_RESET);
      last_cmd_q <= CMD_IDLE;
      suppress_q <= 1'b0;
      stale_pending_q <= 1'b0;
      early_done_q <= 1'b0;
      pe_done_seen_q <= 1'b0;
      reg_rdata <= READ_ZERO;
      command_write_allowed_flag <= 1'b1;
      pe_busy <= 1'b0;
      cmd_done <= 1'b0;
    end else begin
      state_q <= state_d;
      if (wr_filter) filter_shadow_q <= aaf_settings_t'(reg_wdata[7:0]);
      filter_active <= filter_active_d;
      filter_enable_signal <= filter_active_d.enable;
      if (wr_opts) pe_opts_q <= pe_opts_t'(reg_wdata[1:0]);
      if (wr_len) length_q <= CNT_W'(reg_wdata);
      if (cmd_ok || start_reset) last_cmd_q <= cmd_code_t'(cmd_code);
      if (start_load) suppress_q <= suppress;
      // reset during a filtered draw leaves the old options latched
      if (start_reset && busy && filter_active.enable) stale_pending_q <= 1'b1;
      else if (start_draw) stale_pending_q <= 1'b0;
      // early report marks that idle then soft reset must follow
      if (pe_report && trk_running) early_done_q <= 1'b1;
      else if (start_reset) early_done_q <= 1'b0;
      if (trk_proc_done || pe_report) pe_done_seen_q <= 1'b1;
      else if (cmd_ok) pe_done_seen_q <= 1'b0;
      reg_rdata <= reg_rd ? rdata_d : READ_ZERO;
      command_write_allowed_flag <= (state_d == ST_IDLE);
      pe_busy <= (state_d == ST_RUN);
      cmd_done <= (state_q != ST_DONE) && (state_d == ST_DONE);
    end
  end

endmodule // draw_command_sequencing

// ===== tb/draw_seq_chk.sv
/* checker for the draw sequencer port timing.
   assumes it is bound onto draw_command_sequencing. */
`timescale 1ns/1ps
module draw_seq_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // observed ports
  input wire logic [draw_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [draw_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [draw_seq_pkg::DATA_W-1:0] reg_rdata,
  input wire draw_seq_pkg::aaf_settings_t filter_active,
  input wire logic filter_enable_signal,
  input wire logic command_write_allowed_flag,
  input wire logic pe_busy,
  input wire logic cmd_done
);
  import draw_seq_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire cmd_wr = reg_wr && reg_addr == OFS_COMMAND;
  wire take = cmd_wr && command_write_allowed_flag;
  wire [3:0] code = reg_wdata[3:0];
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == READ_ZERO) else $error("rdata not zero");
  enable_mirror_a: assert property (filter_enable_signal == filter_active.enable) else $error("enable mismatch");
  done_pulse_a: assert property (cmd_done |=> !cmd_done) else $error("done too long");
  busy_lock_a: assert property (pe_busy |-> !command_write_allowed_flag) else $error("accepts while busy");
  shadow_hold_a: assert property (reg_wr && reg_addr == OFS_FILTER && !$past(reg_wr) && !$past(reg_wr, 2)
    |=> $stable(filter_active)) else $error("filter write went live");
  idle_quiet_a: assert property (take && code == CMD_IDLE
    |=> (cmd_done && $stable(filter_active)) ##1 $stable(filter_active)) else $error("idle wrong");
  reset_silent_a: assert property (cmd_wr && code == CMD_SOFT_RESET
    |=> !cmd_done [*2] ##[0:3] command_write_allowed_flag) else $error("soft reset wrong");
  load_start_a: assert property (take && code inside {[CMD_PUT_TXT_BM:CMD_PUT_PK]}
    |=> pe_busy && !command_write_allowed_flag) else $error("load not started");
endmodule // draw_seq_chk

bind draw_command_sequencing draw_seq_chk chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .filter_active, .filter_enable_signal, .command_write_allowed_flag, .pe_busy, .cmd_done);

// ===== tb/host_model.sv
/* host model: issues register cycles and command sequences.
   assumes one core clock; signals change right after rising edges. */
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic [draw_seq_pkg::ADDR_W-1:0] reg_addr,
  output logic [draw_seq_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [draw_seq_pkg::DATA_W-1:0] reg_rdata
);
  import draw_seq_pkg::*;
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  task automatic cmd(input logic [3:0] c);
    wr(OFS_COMMAND, {12'h000, c});
  endtask
  // idle first so the running draw keeps its settings
  task automatic set_filter(input logic [7:0] f);
    cmd(CMD_IDLE);
    repeat (3) @(posedge core_clk);
    wr(OFS_FILTER, {8'h00, f});
  endtask
  task automatic soft_rst;
    cmd(CMD_SOFT_RESET);
    cmd(CMD_IDLE);
  endtask
endmodule // host_model

// ===== tb/testbench.sv
/* testbench for the draw sequencer: command table, then hand cases.
   assumes host_model drives the register port. */
`timescale 1ns/1ps
module testbench;
  import draw_seq_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, filter_enable_signal, command_write_allowed_flag, pe_busy, cmd_done;
  aaf_settings_t filter_active;
  int fail_count = 0;
  int samples_checked = 0;
  // {code, load expected}
  localparam logic [4:0] ROWS [7] = '{5'h00, 5'h05, 5'h07, 5'h09, 5'h0B, 5'h0C, 5'h0E};
  always #50 core_clk = ~core_clk;
  host_model h (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  draw_command_sequencing uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .filter_active, .filter_enable_signal, .command_write_allowed_flag, .pe_busy, .cmd_done);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_done !== 1'b1 && n < 300);
    if (cmd_done !== 1'b1) begin
      chk("cmd_done", 16'h0001, 16'h0000);
      end_sim;
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    h.rd(OFS_STATUS, d); chk("status", 16'h0002, d);
    h.rd(OFS_PE_OPTS, d); chk("pe_opts", 16'h0002, d);
    h.rd(OFS_LENGTH, d); chk("length", LENGTH_RESET, d);
    h.rd(4'hF, d); chk("unmapped", READ_ZERO, d);
    for (int i = 0; i < 7; i++) begin
      h.cmd(ROWS[i][4:1]);
      #1 chk("pe_busy", {15'h0000, ROWS[i][0]}, {15'h0000, pe_busy});
      wait_done;
    end
    h.set_filter(8'h9A);
    chk("held", 16'h0000, {8'h00, filter_active});
    h.cmd(CMD_DRAW_LINE); wait_done;
    chk("applied", 16'h009A, {8'h00, filter_active});
    h.set_filter(8'hC5);
    h.wr(OFS_LENGTH, 16'h0020);
    h.cmd(CMD_PUT_BM);
    h.cmd(CMD_DRAW_RECT);
    h.rd(OFS_LAST_CMD, d); chk("last_cmd", 16'h0004, d);
    h.soft_rst; wait_done;
    h.set_filter(8'h00);
    h.cmd(CMD_DRAW_LINE); wait_done;
    chk("dummy", 16'h00C5, {8'h00, filter_active});
    chk("dummy_en", 16'h0001, {15'h0000, filter_enable_signal});
    h.cmd(CMD_DRAW_LINE); wait_done;
    chk("after", 16'h0000, {8'h00, filter_active});
    chk("after_en", 16'h0000, {15'h0000, filter_enable_signal});
    h.wr(OFS_LENGTH, 16'h0008);
    h.wr(OFS_PE_OPTS, 16'h0000);
    h.cmd(CMD_PUT_TXT_BM); wait_done;
    h.rd(OFS_STATUS, d); chk("early_set", 16'h0016, d & 16'h001F);
    h.cmd(CMD_IDLE); wait_done;
    h.soft_rst; wait_done;
    h.rd(OFS_STATUS, d); chk("early", 16'h0002, d & 16'h0006);
    h.wr(OFS_PE_OPTS, 16'h0003);
    h.cmd(CMD_PUT_BM); wait_done;
    h.cmd(CMD_DRAW_LINE); wait_done;
    end_sim;
  end
endmodule // testbench
